/* File: hdl/fault_status_flag_bank.sv */
/*
  read-only status flag bank with read-to-clear latched shadows.
  assumes: the serial port engine on clk issues one-cycle rd/wr strobes;
  comparator conditions and the ac sense pin are asynchronous.
*/
// What this block does
// - fault_status_a bit 6 is high while output undervoltage is sensed.
// - fault_status_a bit 7 is high while output overvoltage is sensed.
// - health_status_b bit 0 is high while supply rail overvoltage is sensed.
// - health_status_b bit 1 low when external reference overloaded, else high.
// - health_status_b bit 2 low when internal reference lost integrity.
// - health_status_b bit 3 low when ground connection is open.
// - supply_good bit 4 low on lockout, reference, ground or supply overvoltage fault.
// - health_status_b bit 5 low on excessive output switch reverse voltage.
// - bit 6 low when pulse, power-enable, load-voltage or reverse indication false.
// - health_status_b bit 7 low when current share accuracy out of limits.
// - fault_status_c bit 0 latches overvoltage, undervoltage or overcurrent timeout.
// - fault_status_c bit 1 shows pulses present on the ac sense input.
// - fault_status_a bit 5 high once overcurrent persisted past its timer.
// - latched copies clear on read unless the fault is still present.
`timescale 1ns/1ps
`include "fault_status_flag_bank_regs.svh"

module fault_status_flag_bank #(
  parameter int OCP_TIMEOUT_CYC = `FSFB_OCP_TIME_US * `FSFB_CLK_MHZ,
  parameter int PULSE_WINDOW_CYC = `FSFB_PULSE_WINDOW_US * `FSFB_CLK_MHZ
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire fault_status_pkg::fault_in_t cond_in,
  input wire logic ac_sense,
  input wire logic fault_clr,
  input wire fault_status_pkg::reg_req_t reg_req,
  output logic [7:0] reg_rdata_q,
  output logic reg_rvalid_q,
  output logic fault_latch_q
);
  import fault_status_pkg::*;

  localparam int OCW = $clog2(OCP_TIMEOUT_CYC + 1);
  localparam int PWW = $clog2(PULSE_WINDOW_CYC + 1);
  localparam logic [OCW-1:0] OCP_MAX = OCW'(OCP_TIMEOUT_CYC);
  localparam logic [PWW-1:0] PW_MAX = PWW'(PULSE_WINDOW_CYC);
  localparam logic [7:0] POL [3] = '{`FSFB_POL_A, `FSFB_POL_B, `FSFB_POL_C};
  localparam logic [7:0] VALID [3] = '{`FSFB_VALID_A, `FSFB_VALID_B, `FSFB_VALID_C};

  // ==========================================================
  // address decode: {latch c, latch b, latch a, c, b, a}
  function automatic logic [5:0] addr_hit(input logic [7:0] a);
    logic [5:0] h;
    h = 6'h00;
    h[0] = (a == `FSFB_OFS_FAULT_STATUS_A);
    h[1] = (a == `FSFB_OFS_HEALTH_STATUS_B);
    h[2] = (a == `FSFB_OFS_FAULT_STATUS_C);
    h[3] = (a == `FSFB_OFS_LATCH_A);
    h[4] = (a == `FSFB_OFS_LATCH_B);
    h[5] = (a == `FSFB_OFS_LATCH_C);
    return h;
  endfunction

  fault_in_t meta_q;
  fault_in_t sync_q;
  logic ac_meta_q;
  logic ac_sync_q;
  logic ac_prev_q;
  logic [PWW-1:0] pw_cnt_q;
  logic [OCW-1:0] ocp_cnt_q;
  logic pulse_ok;
  logic ocpto;
  logic supply_good;
  logic orfet_ok;
  logic ac_edge;
  logic rd_acc;
  logic [5:0] hit;
  logic [7:0] stat_d [3];
  logic [7:0] stat_q [3];
  logic [7:0] latch_q [3];
  logic [7:0] rd_mux;

  // ==========================================================
  // synchronisers
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= cond_in;
      sync_q <= meta_q;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ac_meta_q <= 1'b0;
      ac_sync_q <= 1'b0;
      ac_prev_q <= 1'b0;
    end
    else
    begin
      ac_meta_q <= ac_sense;
      ac_sync_q <= ac_meta_q;
      ac_prev_q <= ac_sync_q;
    end
  end

  assign ac_edge = ac_sync_q & ~ac_prev_q;

  // ==========================================================
  // ac sense pulse watchdog
  // starts expired so no pulses are claimed before the first edge
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      pw_cnt_q <= PW_MAX;
    else if (ac_edge)
      pw_cnt_q <= '0;
    else if (pw_cnt_q != PW_MAX)
      pw_cnt_q <= pw_cnt_q + 1'b1;
  end

  assign pulse_ok = (pw_cnt_q != PW_MAX);

  // ==========================================================
  // overcurrent timer
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      ocp_cnt_q <= '0;
    else if (!sync_q.oc)
      ocp_cnt_q <= '0;
    else if (ocp_cnt_q != OCP_MAX)
      ocp_cnt_q <= ocp_cnt_q + 1'b1;
  end

  assign ocpto = (ocp_cnt_q == OCP_MAX);

  // ==========================================================
  // fault latch; a new fault wins over a clear in the same cycle
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      fault_latch_q <= 1'b0;
    else
      fault_latch_q <= sync_q.ov | sync_q.uv | ocpto | (fault_latch_q & ~fault_clr);
  end

  // ==========================================================
  // live status
  assign supply_good = ~sync_q.below_lockout & sync_q.extref_ok & sync_q.intref_ok
                     & sync_q.gnd_ok & ~sync_q.vdd_ov;
  assign orfet_ok = pulse_ok & sync_q.pen_ok & sync_q.loadv_ok & sync_q.reverse_ok;

  always_comb
  begin
    stat_d[0] = {sync_q.ov, sync_q.uv, ocpto, sync_q.mon};
    stat_d[1] = {sync_q.share_ok, orfet_ok, sync_q.reverse_ok, supply_good,
                 sync_q.gnd_ok, sync_q.intref_ok, sync_q.extref_ok, sync_q.vdd_ov};
    stat_d[2] = {6'h00, pulse_ok, fault_latch_q};
  end

  // ==========================================================
  // register access; a strobe with wr set is dropped whole
  assign hit = addr_hit(reg_req.addr);
  assign rd_acc = reg_req.rd & ~reg_req.wr;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_reg
      always_ff @(posedge clk or negedge arst_n)
      begin
        if (!arst_n)
          stat_q[gi] <= `FSFB_RST_STATUS;
        else
          stat_q[gi] <= stat_d[gi];
      end

      // present fault re-sets the copy, so it survives its own read
      // low-active bits come up latched from reset; software reads them clear once
      always_ff @(posedge clk or negedge arst_n)
      begin
        if (!arst_n)
          latch_q[gi] <= `FSFB_RST_LATCH;
        else
          latch_q[gi] <= ((stat_q[gi] ^ POL[gi]) & VALID[gi])
                       | (latch_q[gi] & ~{8{rd_acc & hit[gi+3]}});
      end
    end
  endgenerate

  always_comb
  begin
    rd_mux = `FSFB_RDATA_UNMAPPED;
    for (int i = 0; i < 3; i++)
    begin
      if (hit[i])
        rd_mux = stat_q[i];
      if (hit[i+3])
        rd_mux = latch_q[i];
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      reg_rvalid_q <= 1'b0;
      reg_rdata_q <= 8'h00;
    end
    else
    begin
      reg_rvalid_q <= rd_acc;
      if (rd_acc)
        reg_rdata_q <= rd_mux;
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  uv_read_a: assert property (rd_acc && hit[0] |=> reg_rdata_q[`FSFB_BIT_UV] == $past(sync_q.uv, 2))
    else $error("undervoltage bit read wrong");
  ov_read_a: assert property (rd_acc && hit[0] |=> reg_rdata_q[`FSFB_BIT_OV] == $past(sync_q.ov, 2))
    else $error("overvoltage bit read wrong");
  vddov_flag_a: assert property ($rose(sync_q.vdd_ov) |=> stat_q[1][`FSFB_BIT_VDD_OV])
    else $error("supply overvoltage bit not set");
  extref_flag_a: assert property (!sync_q.extref_ok |=> !stat_q[1][`FSFB_BIT_EXTREF_OK])
    else $error("external reference bit not cleared");
  intref_flag_a: assert property (!sync_q.intref_ok |=> !stat_q[1][`FSFB_BIT_INTREF_OK])
    else $error("internal reference bit not cleared");
  gnd_flag_a: assert property (!sync_q.gnd_ok |=> !stat_q[1][`FSFB_BIT_GND_OK])
    else $error("ground bit not cleared");
  supply_good_a: assert property (sync_q.below_lockout || sync_q.vdd_ov || !sync_q.gnd_ok
                                  || !sync_q.extref_ok || !sync_q.intref_ok |=> !stat_q[1][`FSFB_BIT_SUPPLY_GOOD])
    else $error("supply good not cleared");
  reverse_flag_a: assert property (!sync_q.reverse_ok |=> !stat_q[1][`FSFB_BIT_REVERSE_OK])
    else $error("reverse voltage bit not cleared");
  orfet_pulse_a: assert property (!pulse_ok || !sync_q.loadv_ok |=> !stat_q[1][`FSFB_BIT_ORFET_OK])
    else $error("output switch good not cleared");
  share_flag_a: assert property (!sync_q.share_ok |=> !stat_q[1][`FSFB_BIT_SHARE_OK])
    else $error("share bit not cleared");
  fault_hold_a: assert property (fault_latch_q && !fault_clr |=> fault_latch_q ##1 stat_q[2][`FSFB_BIT_FAULT])
    else $error("fault latch dropped without clear");
  fault_set_a: assert property (sync_q.ov |=> fault_latch_q)
    else $error("fault latch not set on overvoltage");
  pulse_edge_a: assert property (ac_edge |-> ##2 stat_q[2][`FSFB_BIT_PULSE_OK])
    else $error("pulse present not shown after edge");
  ocp_timeout_a: assert property (sync_q.oc && ocp_cnt_q == OCP_MAX - 1'b1 && $past(sync_q.oc)
                                  |=> ##1 stat_q[0][`FSFB_BIT_OCPTO])
    else $error("overcurrent timeout bit late");
  ocp_early_a: assert property (!sync_q.oc |=> ##1 !stat_q[0][`FSFB_BIT_OCPTO])
    else $error("overcurrent timeout without overcurrent");
  latch_keep_a: assert property (rd_acc && hit[3] && stat_q[0][`FSFB_BIT_UV] |=> latch_q[0][`FSFB_BIT_UV])
    else $error("latched copy cleared with fault present");
  latch_clear_a: assert property (rd_acc && hit[3] && !stat_q[0][`FSFB_BIT_UV] |=> !latch_q[0][`FSFB_BIT_UV])
    else $error("latched copy not cleared by read");
  write_drop_a: assert property (reg_req.wr |=> !reg_rvalid_q)
    else $error("write produced a read answer");
  uv_flag_a: assert property (sync_q.uv |=> stat_q[0][`FSFB_BIT_UV])
    else $error("undervoltage bit not set");
  ov_flag_a: assert property (sync_q.ov |=> stat_q[0][`FSFB_BIT_OV])
    else $error("overvoltage bit not set");
  vddov_clear_a: assert property (!sync_q.vdd_ov |=> !stat_q[1][`FSFB_BIT_VDD_OV])
    else $error("supply overvoltage bit set without fault");
  extref_good_a: assert property (sync_q.extref_ok |=> stat_q[1][`FSFB_BIT_EXTREF_OK])
    else $error("external reference bit low without fault");
  intref_good_a: assert property (sync_q.intref_ok |=> stat_q[1][`FSFB_BIT_INTREF_OK])
    else $error("internal reference bit low without fault");
  gnd_good_a: assert property (sync_q.gnd_ok |=> stat_q[1][`FSFB_BIT_GND_OK])
    else $error("ground bit low without fault");
  supply_set_a: assert property (!sync_q.below_lockout && sync_q.extref_ok && sync_q.intref_ok
                                 && sync_q.gnd_ok && !sync_q.vdd_ov |=> stat_q[1][`FSFB_BIT_SUPPLY_GOOD])
    else $error("supply good low without fault");
  reverse_good_a: assert property (sync_q.reverse_ok |=> stat_q[1][`FSFB_BIT_REVERSE_OK])
    else $error("reverse voltage bit low without fault");
  orfet_pen_a: assert property (!sync_q.pen_ok || !sync_q.reverse_ok |=> !stat_q[1][`FSFB_BIT_ORFET_OK])
    else $error("output switch good not cleared");
  orfet_good_a: assert property (pulse_ok && sync_q.pen_ok && sync_q.loadv_ok && sync_q.reverse_ok
                                 |=> stat_q[1][`FSFB_BIT_ORFET_OK])
    else $error("output switch good low without cause");
  share_good_a: assert property (sync_q.share_ok |=> stat_q[1][`FSFB_BIT_SHARE_OK])
    else $error("share bit low without fault");
  fault_others_a: assert property (sync_q.uv || ocpto |=> fault_latch_q)
    else $error("fault latch not set on undervoltage or timeout");
  fault_release_a: assert property (fault_clr && !sync_q.ov && !sync_q.uv && !ocpto |=> !fault_latch_q)
    else $error("fault latch not released");
  pulse_lost_a: assert property (pw_cnt_q == PW_MAX - 1'b1 && !ac_edge
                                 |=> ##1 !stat_q[2][`FSFB_BIT_PULSE_OK])
    else $error("pulse present kept after window");
  ocp_hold_a: assert property (ocpto && sync_q.oc |=> ocpto)
    else $error("overcurrent timeout dropped with overcurrent");
  latch_set_a: assert property (!stat_q[1][`FSFB_BIT_GND_OK] |=> latch_q[1][`FSFB_BIT_GND_OK])
    else $error("ground fault not latched");
  write_keep_a: assert property (reg_req.wr && hit[4]
                                 |=> (latch_q[1] & $past(latch_q[1])) == $past(latch_q[1]))
    else $error("write cleared a latched copy");

  read_latch_c: cover property (rd_acc && hit[4] && latch_q[1] != 8'h00);
  fault_clear_c: cover property (fault_latch_q && fault_clr && !sync_q.ov && !sync_q.uv);
  ocp_expire_c: cover property (ocpto);
  pulse_loss_c: cover property ($fell(pulse_ok));
  write_ignore_c: cover property (reg_req.wr && reg_req.rd && hit[4]);

endmodule // fault_status_flag_bank

/* File: hdl/fault_status_flag_bank_regs.svh */
/*
  register offsets, bit positions, polarity masks, reset values and timing
  figures of the fault status flag bank.
  assumes: included by bare name from the package and the design module.
*/
`ifndef FAULT_STATUS_FLAG_BANK_REGS_SVH
`define FAULT_STATUS_FLAG_BANK_REGS_SVH

// ==========================================================
// offsets
`define FSFB_OFS_FAULT_STATUS_A 8'h00
`define FSFB_OFS_HEALTH_STATUS_B 8'h01
`define FSFB_OFS_FAULT_STATUS_C 8'h02
`define FSFB_OFS_LATCH_A 8'h2a
`define FSFB_OFS_LATCH_B 8'h2b
`define FSFB_OFS_LATCH_C 8'h2c

// ==========================================================
// bit positions
`define FSFB_BIT_OCPTO 5
`define FSFB_BIT_UV 6
`define FSFB_BIT_OV 7
`define FSFB_BIT_VDD_OV 0
`define FSFB_BIT_EXTREF_OK 1
`define FSFB_BIT_INTREF_OK 2
`define FSFB_BIT_GND_OK 3
`define FSFB_BIT_SUPPLY_GOOD 4
`define FSFB_BIT_REVERSE_OK 5
`define FSFB_BIT_ORFET_OK 6
`define FSFB_BIT_SHARE_OK 7
`define FSFB_BIT_FAULT 0
`define FSFB_BIT_PULSE_OK 1

// ==========================================================
// fault polarity (1 = flag low means fault) and implemented bits
`define FSFB_POL_A 8'h00
`define FSFB_POL_B 8'hfe
`define FSFB_POL_C 8'h02
`define FSFB_VALID_A 8'hff
`define FSFB_VALID_B 8'hff
`define FSFB_VALID_C 8'h03
`define FSFB_RST_STATUS 8'h00
`define FSFB_RST_LATCH 8'h00
`define FSFB_RDATA_UNMAPPED 8'h00

// ==========================================================
// timing
`define FSFB_CLK_MHZ 25
`define FSFB_OCP_TIME_US 1000
`define FSFB_PULSE_WINDOW_US 20000

`endif

/* File: hdl/fault_status_pkg.sv */
/*
  types shared by the fault status flag bank.
  assumes: nothing beyond the register header.
*/
`include "fault_status_flag_bank_regs.svh"

package fault_status_pkg;

  // raw conditions from the analog comparators, all asynchronous
  typedef struct packed {
    logic ov;
    logic uv;
    logic oc;
    logic vdd_ov;
    logic extref_ok;
    logic intref_ok;
    logic gnd_ok;
    logic below_lockout;
    logic reverse_ok;
    logic pen_ok;
    logic loadv_ok;
    logic share_ok;
    logic [4:0] mon;
  } fault_in_t;

  // register access from the serial management port engine
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
  } reg_req_t;

endpackage

/* File: test/tb_top.sv */
/*
  self-checking bench for the fault status flag bank: drives conditions,
  ac sense pulses and register strobes, and checks every read answer except the latch-clearing reads, whose mask is zero.
  assumes: the flag bank package and module compile ahead of this file.
*/
`timescale 1ns/1ps

module tb_top;
  import fault_status_pkg::*;

  // ==========================================================
  // stimulus and design
  localparam fault_in_t BASE = 17'h01de0;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic ac_sense = 1'b0;
  logic fault_clr = 1'b0;
  logic pulse_en = 1'b0;
  fault_in_t c = BASE;
  reg_req_t rq = '0;
  logic [7:0] rdata;
  logic rvalid;
  logic fl;
  logic [15:0] e;
  logic [15:0] expq[$];
  int fails = 0;
  int checked = 0;
  int pc = 0;
  logic pon = 1'b0;
  logic flt = 1'b0;
  logic ocp = 1'b0;

  always #20 clk = ~clk;

  fault_status_flag_bank #(
    .OCP_TIMEOUT_CYC(8),
    .PULSE_WINDOW_CYC(16)
  ) dut_u (
    .clk(clk),
    .arst_n(arst_n),
    .cond_in(c),
    .ac_sense(ac_sense),
    .fault_clr(fault_clr),
    .reg_req(rq),
    .reg_rdata_q(rdata),
    .reg_rvalid_q(rvalid),
    .fault_latch_q(fl)
  );

  // rising edge every 8 cycles, well inside the 16 cycle window
  always @(posedge clk)
  begin
    pc <= pc + 1;
    ac_sense <= #1 pulse_en & pc[2];
  end

  // ==========================================================
  // result watcher
  task automatic cmp_rd(input logic [7:0] ex, input logic [7:0] m, input logic [7:0] got);
    checked++;
    if (((got ^ ex) & m) !== 8'h00)
    begin
      fails++;
      $display("wrong value at %0t: exp %h got %h", $time, ex, got);
    end
  endtask

  task automatic cmp_fl(input logic ex, input logic got);
    checked++;
    if (got !== ex)
    begin
      fails++;
      $display("wrong value at %0t: exp %h got %h", $time, ex, got);
    end
  endtask

  always @(posedge clk)
  begin
    if (rvalid === 1'b1)
    begin
      if (expq.size() == 0)
      begin
        fails++;
        $display("wrong value at %0t: exp none got %h", $time, rdata);
      end
      else
      begin
        e = expq.pop_front();
        cmp_rd(e[7:0], e[15:8], rdata);
      end
    end
  end

  // ==========================================================
  // bus tasks
  task automatic rd(input logic [7:0] a, input logic [7:0] ex, input logic [7:0] m);
    @(posedge clk) #1;
    rq = {1'b1, 1'b0, a};
    expq.push_back({m, ex});
    @(posedge clk) #1;
    rq = '0;
  endtask

  task automatic chk;
    logic sg;
    repeat (5) @(posedge clk);
    #1 cmp_fl(flt, fl);
    sg = !c.below_lockout & c.extref_ok & c.intref_ok & c.gnd_ok & !c.vdd_ov;
    rd(8'h00, {c.ov, c.uv, ocp, c.mon}, 8'hff);
    rd(8'h01, {c.share_ok, pon & c.pen_ok & c.loadv_ok & c.reverse_ok, c.reverse_ok, sg,
      c.gnd_ok, c.intref_ok, c.extref_ok, c.vdd_ov}, 8'hff);
    rd(8'h02, {6'h00, pon, flt}, 8'hff);
  endtask

  task automatic clear_latches;
    rd(8'h2a, 8'h00, 8'h00);
    rd(8'h2b, 8'h00, 8'h00);
    rd(8'h2c, 8'h00, 8'h00);
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ==========================================================
  // sequence
  initial
  begin
    #400000;
    fails++;
    wrap_up;
  end

  initial
  begin
    void'($urandom(39022));
    repeat (6) @(posedge clk);
    #1 arst_n = 1'b1;
    chk;
    pulse_en = 1'b1;
    repeat (20) @(posedge clk);
    pon = 1'b1;
    chk;
    // one condition at a time; oc skipped, its timer would run out mid-check
    for (int k = 5; k < 17; k++)
    begin
      if (k == 14)
        continue;
      c = BASE;
      c[k] = ~c[k];
      if (c.ov | c.uv)
        flt = 1'b1;
      chk;
      if (k == 15)
        rd(8'h2a, 8'h40, 8'hff);
    end
    c = BASE;
    repeat (4)
    begin
      c.mon = 5'($urandom);
      chk;
    end
    @(posedge clk) #1;
    rq = {1'b0, 1'b1, 8'h00};
    @(posedge clk) #1;
    rq = {1'b1, 1'b1, 8'h01};
    @(posedge clk) #1;
    rq = '0;
    chk;
    c.oc = 1'b1;
    repeat (4) @(posedge clk);
    rd(8'h00, {3'b000, c.mon}, 8'hff);
    repeat (20) @(posedge clk);
    ocp = 1'b1;
    chk;
    c.oc = 1'b0;
    ocp = 1'b0;
    chk;
    @(posedge clk) #1;
    fault_clr = 1'b1;
    @(posedge clk) #1;
    fault_clr = 1'b0;
    flt = 1'b0;
    chk;
    clear_latches;
    c.gnd_ok = 1'b0;
    repeat (5) @(posedge clk);
    rd(8'h2b, 8'h18, 8'hff);
    rd(8'h2b, 8'h18, 8'hff);
    c.gnd_ok = 1'b1;
    repeat (5) @(posedge clk);
    @(posedge clk) #1;
    rq = {1'b1, 1'b1, 8'h2b};
    @(posedge clk) #1;
    rq = '0;
    rd(8'h2b, 8'h18, 8'hff);
    rd(8'h2b, 8'h00, 8'hff);
    rd(8'h2a, {3'b000, c.mon}, 8'hff);
    rd(8'h2c, 8'h00, 8'hff);
    rd(8'h10, 8'h00, 8'hff);
    pulse_en = 1'b0;
    repeat (30) @(posedge clk);
    pon = 1'b0;
    chk;
    rd(8'h2c, 8'h02, 8'hff);
    for (int n = 0; n < 20 && expq.size() != 0; n++)
      @(posedge clk);
    if (expq.size() != 0)
      fails++;
    wrap_up;
  end
endmodule // tb_top
